// ---- rtl/ppl_lock.sv ----
`timescale 1ns/1ps
`include "ppl_regs.svh"

// Overview of operation
// - Level resets to no-lock; only listed levels
// - Password 1000..9998 registers when level set
// - Writing 0 or 9999 accepted, no change
// - Levels 0..3 permission rows per source
// - Levels 4..6 permission rows per source
// - Levels 99/199 allow user-group parameters
// - Non-group parameters follow level four row
// - Group read selection block refuses reads
// - Write selection block refuses writes
// - Lock parameters accessible regardless of group
// - Levels 0/100 with option trip fault
// - Level writable only when group selection zero
// - Password writable when locked, else selection zero
// - Lock parameters ignore write selection setting
// - Registered password restricts until unlock
// - Password reads back 9999 when unset, else count or zero
// - Counting levels count failures, lock at five
// - Matching password unlocks; mismatch flags error
// - After five failures correct password refused
// - Full clear while stopped unlocks, clears everything
// - Lock refusal shows lock indication
// - Internal updates of other parameters bypass the lock
// - Full clear refused while drive runs
module ppl_lock (
   input  wire logic              clk_sys,              // 10 MHz system clock
   input  wire logic              rst_n,                // Async reset, active low
   input  wire logic              req_valid,            // Access request strobe
   input  wire ppl_pkg::ppl_src_e req_src,              // Requesting source
   input  wire logic              req_write,            // 1 write, 0 read
   input  wire ppl_pkg::ppl_tgt_e req_tgt,              // Targeted parameter class
   input  wire logic              req_user_grp,         // Target is in user group
   input  wire logic [15:0]       req_wdata,            // Write value
   input  wire logic [15:0]       group_read_selection, // Group read selection value
   input  wire logic              read_sel_block,       // Group selection hides target
   input  wire logic              write_sel_block,      // Write selection forbids write
   input  wire logic              option_installed,     // Option present, async pin
   input  wire logic              drive_running,        // Motor running, async pin
   input  wire logic              all_clear_req,        // Full parameter clear strobe
   output logic                   rsp_valid,            // Answer strobe
   output logic                   rsp_ok,               // Request carried out
   output logic                   rsp_err,              // Value or unlock error
   output logic                   rsp_lock_ind,         // Refused by password lock
   output logic [15:0]            rsp_rdata,            // Read value of lock params
   output logic [15:0]            lock_level_setting,   // Current lock level
   output logic                   locked,               // Password registered
   output logic                   lockout,              // Five failures reached
   output logic                   option_fault_trip,    // Option fault, trip
   output logic                   all_clear_ack,        // Full clear done
   output logic                   all_clear_refused,    // Full clear refused
   output logic                   param_clear           // Clear other parameters
);

   logic [15:0] lvl_ff;
   logic [15:0] pw_ff;
   logic        pw_set_ff;
   logic [2:0]  fail_ff;
   logic        opt_meta_ff;
   logic        opt_sync_ff;
   logic        run_meta_ff;
   logic        run_sync_ff;
   logic        rsp_valid_ff;
   logic        rsp_ok_ff;
   logic        rsp_err_ff;
   logic        rsp_lock_ind_ff;
   logic [15:0] rsp_rdata_ff;
   logic        lockout_ff;
   logic        opt_fault_ff;
   logic        clr_ack_ff;
   logic        clr_ref_ff;

   logic [15:0] nxt_lvl;
   logic [15:0] nxt_pw;
   logic        nxt_pw_set;
   logic [2:0]  nxt_fail;
   logic        nxt_ok;
   logic        nxt_err;
   logic        nxt_lock_ind;
   logic [15:0] nxt_rdata;

   function automatic logic f_counting(input logic [15:0] v);
      f_counting = ((v >= `PPL_LVL_CNT_BASE) && (v <= `PPL_LVL_CNT_MAX))
                 || (v == `PPL_LVL_UG_CNT);
   endfunction : f_counting

   function automatic logic f_level_ok(input logic [15:0] v);
      f_level_ok = (v <= `PPL_LVL_BASE_MAX) || (v == `PPL_LVL_UG)
                 || f_counting(v) || (v == `PPL_LVL_NONE);
   endfunction : f_level_ok

   // Decode of the current request
   logic is_int;
   logic tgt_lvl;
   logic tgt_pw;
   logic sel_zero;
   logic cnt_lvl;
   logic mat_allow;
   logic gen_ok;
   logic sel_ok;
   logic pw_noop;
   logic pw_range;
   logic pw_match;
   logic at_max;
   logic lvl_wr_ok;
   logic pw_wr_ok;
   logic do_clear;

   // Status and read-back terms
   logic        nxt_lockout;
   logic        nxt_opt_fault;
   logic        clr_refuse;
   logic [15:0] pw_rdval;

   assign is_int   = (req_src == ppl_pkg::PPL_SRC_INTERNAL);
   assign tgt_lvl  = (req_tgt == ppl_pkg::PPL_TGT_LEVEL);
   assign tgt_pw   = (req_tgt == ppl_pkg::PPL_TGT_PASSWORD);
   assign sel_zero = (group_read_selection == 16'h0000);
   assign cnt_lvl  = f_counting(lvl_ff);
   assign pw_noop  = (req_wdata == `PPL_PW_NOOP_LO) || (req_wdata == `PPL_PW_NOOP_HI);
   assign pw_range = (req_wdata >= `PPL_PW_MIN) && (req_wdata <= `PPL_PW_MAX);
   assign pw_match = (req_wdata == pw_ff);
   assign at_max   = (fail_ff == `PPL_FAIL_MAX);

   ppl_perm_matrix u_matrix (
      .level    (lvl_ff),
      .src      (req_src),
      .wr       (req_write),
      .user_grp (req_user_grp),
      .allow    (mat_allow)
   );

   // Restriction applies only once a password is registered
   assign gen_ok    = !pw_set_ff || mat_allow;
   assign sel_ok    = is_int
                    || (req_write ? !write_sel_block
                                  : !read_sel_block);
   // Lock parameters skip write selection and the matrix, but unarmed writes still need group selection zero
   assign lvl_wr_ok = !pw_set_ff && sel_zero;
   assign pw_wr_ok  = pw_set_ff
                    || ((lvl_ff != `PPL_LVL_NONE) && sel_zero);
   // Clear is refused while the motor runs
   assign do_clear  = all_clear_req && !run_sync_ff;

   // Lockout follows the state being written, so it lands with the count
   assign nxt_lockout   = f_counting(nxt_lvl) && (nxt_fail == `PPL_FAIL_MAX);
   // Deny-all level cannot coexist with an option
   assign nxt_opt_fault = opt_sync_ff
                        && ((lvl_ff == 16'h0000) || (lvl_ff == `PPL_LVL_CNT_BASE));
   assign clr_refuse    = all_clear_req && run_sync_ff;

   // Password reads show the failure count at most, never the value
   assign pw_rdval      = !pw_set_ff ? pw_ff
                        : (cnt_lvl ? {13'h0000, fail_ff} : 16'h0000);

   always_comb begin
      nxt_lvl      = lvl_ff;
      nxt_pw       = pw_ff;
      nxt_pw_set   = pw_set_ff;
      nxt_fail     = fail_ff;
      nxt_ok       = 1'b0;
      nxt_err      = 1'b0;
      nxt_lock_ind = 1'b0;
      nxt_rdata    = 16'h0000;
      if (req_valid) begin
         if (tgt_lvl) begin
            if (!req_write) begin
               nxt_ok    = 1'b1;
               nxt_rdata = lvl_ff;
            end else if (!lvl_wr_ok) begin
               // A selection refusal while unarmed is no lock refusal
               nxt_lock_ind = pw_set_ff;
            end else if (f_level_ok(req_wdata)) begin
               nxt_ok  = 1'b1;
               nxt_lvl = req_wdata;
            end else begin
               nxt_err = 1'b1;
            end
         end else if (tgt_pw) begin
            if (!req_write) begin
               nxt_ok    = 1'b1;
               nxt_rdata = pw_rdval;
            end else if (!pw_wr_ok) begin
               nxt_err = 1'b1;
            end else if (pw_noop) begin
               nxt_ok = 1'b1;
            end else if (!pw_set_ff) begin
               if (pw_range) begin
                  nxt_ok     = 1'b1;
                  nxt_pw     = req_wdata;
                  nxt_pw_set = 1'b1;
               end else begin
                  nxt_err = 1'b1;
               end
            end else if (cnt_lvl && at_max) begin
               // Even the right password is ignored now
               nxt_err      = 1'b1;
               nxt_lock_ind = 1'b1;
            end else if (pw_match) begin
               nxt_ok     = 1'b1;
               nxt_pw     = `PPL_PW_RST;
               nxt_pw_set = 1'b0;
               nxt_fail   = `PPL_FAIL_RST;
            end else begin
               nxt_err = 1'b1;
               if (cnt_lvl) begin
                  nxt_fail = fail_ff + 3'h1;
               end
            end
         end else if (gen_ok && sel_ok) begin
            nxt_ok = 1'b1;
         end else begin
            nxt_lock_ind = !gen_ok;
         end
      end
      // Clear overrides any update made in the same cycle
      if (do_clear) begin
         nxt_lvl    = `PPL_LVL_RST;
         nxt_pw     = `PPL_PW_RST;
         nxt_pw_set = 1'b0;
         nxt_fail   = `PPL_FAIL_RST;
      end
   end

   // Pin synchronisers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         opt_meta_ff <= 1'b0;
         opt_sync_ff <= 1'b0;
         run_meta_ff <= 1'b0;
         run_sync_ff <= 1'b0;
      end else begin
         opt_meta_ff <= option_installed;
         opt_sync_ff <= opt_meta_ff;
         run_meta_ff <= drive_running;
         run_sync_ff <= run_meta_ff;
      end
   end

   // Lock state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lvl_ff    <= `PPL_LVL_RST;
         pw_ff     <= `PPL_PW_RST;
         pw_set_ff <= 1'b0;
         fail_ff   <= `PPL_FAIL_RST;
      end else begin
         lvl_ff    <= nxt_lvl;
         pw_ff     <= nxt_pw;
         pw_set_ff <= nxt_pw_set;
         fail_ff   <= nxt_fail;
      end
   end

   // Answers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid_ff    <= 1'b0;
         rsp_ok_ff       <= 1'b0;
         rsp_err_ff      <= 1'b0;
         rsp_lock_ind_ff <= 1'b0;
         rsp_rdata_ff    <= 16'h0000;
      end else begin
         rsp_valid_ff    <= req_valid;
         rsp_ok_ff       <= nxt_ok;
         rsp_err_ff      <= nxt_err;
         rsp_lock_ind_ff <= nxt_lock_ind;
         rsp_rdata_ff    <= nxt_rdata;
      end
   end

   // Status and clear handshake
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lockout_ff   <= 1'b0;
         opt_fault_ff <= 1'b0;
         clr_ack_ff   <= 1'b0;
         clr_ref_ff   <= 1'b0;
      end else begin
         lockout_ff   <= nxt_lockout;
         opt_fault_ff <= nxt_opt_fault;
         clr_ack_ff   <= do_clear;
         clr_ref_ff   <= clr_refuse;
      end
   end

   assign rsp_valid          = rsp_valid_ff;
   assign rsp_ok             = rsp_ok_ff;
   assign rsp_err            = rsp_err_ff;
   assign rsp_lock_ind       = rsp_lock_ind_ff;
   assign rsp_rdata          = rsp_rdata_ff;
   assign lock_level_setting = lvl_ff;
   assign locked             = pw_set_ff;
   assign lockout            = lockout_ff;
   assign option_fault_trip  = opt_fault_ff;
   assign all_clear_ack      = clr_ack_ff;
   assign all_clear_refused  = clr_ref_ff;
   // Other parameter settings are wiped with the same pulse
   assign param_clear        = clr_ack_ff;

endmodule : ppl_lock

// ---- rtl/ppl_regs.svh ----
`ifndef PPL_REGS_SVH
`define PPL_REGS_SVH

// Lock level values
`define PPL_LVL_RST       16'h270f
`define PPL_LVL_NONE      16'h270f
`define PPL_LVL_BASE_MAX  16'h0006
`define PPL_LVL_UG        16'h0063
`define PPL_LVL_CNT_BASE  16'h0064
`define PPL_LVL_CNT_MAX   16'h006a
`define PPL_LVL_UG_CNT    16'h00c7
`define PPL_LVL_OPT_RD    16'h0004

// Password entry values
`define PPL_PW_RST        16'h270f
`define PPL_PW_NOOP_LO    16'h0000
`define PPL_PW_NOOP_HI    16'h270f
`define PPL_PW_MIN        16'h03e8
`define PPL_PW_MAX        16'h270e

// Unlock failure counter
`define PPL_FAIL_RST      3'h0
`define PPL_FAIL_MAX      3'h5

`endif

// ---- rtl/ppl_pkg.sv ----
package ppl_pkg;

   typedef enum logic [1:0] {
      PPL_SRC_PANEL,
      PPL_SRC_RS485,
      PPL_SRC_OPTION,
      PPL_SRC_INTERNAL
   } ppl_src_e;

   typedef enum logic [1:0] {
      PPL_TGT_OTHER,
      PPL_TGT_LEVEL,
      PPL_TGT_PASSWORD
   } ppl_tgt_e;

endpackage : ppl_pkg

// ---- rtl/ppl_perm_matrix.sv ----
`timescale 1ns/1ps
`include "ppl_regs.svh"

module ppl_perm_matrix (
   input  wire logic [15:0]       level,    // Current lock level
   input  wire ppl_pkg::ppl_src_e src,      // Requesting source
   input  wire logic              wr,       // 1 write, 0 read
   input  wire logic              user_grp, // Target is in user group
   output logic                   allow     // Access permitted by level
);

   logic [15:0] base;
   logic [15:0] eff;
   logic        ug;
   logic        is_pan;
   logic        is_485;
   logic        is_opt;
   logic        is_int;
   logic        rd_ok;
   logic        wr_ok;

   // Counting levels share the matrix of their base level
   assign base   = (level >= `PPL_LVL_CNT_BASE) ? (level - `PPL_LVL_CNT_BASE) : level;
   assign ug     = (base == `PPL_LVL_UG);
   // Outside the user group the option-read-only row applies
   assign eff    = ug ? `PPL_LVL_OPT_RD : base;
   assign is_pan = (src == ppl_pkg::PPL_SRC_PANEL);
   assign is_485 = (src == ppl_pkg::PPL_SRC_RS485);
   assign is_opt = (src == ppl_pkg::PPL_SRC_OPTION);
   assign is_int = (src == ppl_pkg::PPL_SRC_INTERNAL);

   always_comb begin
      rd_ok = 1'b0;
      wr_ok = 1'b0;
      unique case (eff)
         16'h0000: begin
            rd_ok = 1'b0;
            wr_ok = 1'b0;
         end
         16'h0001: begin
            rd_ok = 1'b1;
            wr_ok = 1'b0;
         end
         16'h0002: begin
            rd_ok = 1'b1;
            wr_ok = !is_pan;
         end
         16'h0003: begin
            rd_ok = 1'b1;
            wr_ok = is_pan;
         end
         16'h0004: begin
            rd_ok = is_opt;
            wr_ok = 1'b0;
         end
         16'h0005: begin
            rd_ok = !is_pan;
            wr_ok = !is_pan;
         end
         16'h0006: begin
            rd_ok = !is_485;
            wr_ok = is_pan;
         end
         default: begin
            // Only no-lock level 9999 lands here, never while armed; deny to be safe
            rd_ok = 1'b0;
            wr_ok = 1'b0;
         end
      endcase
   end

   // Internal updates such as life counters never hit the lock
   assign allow = is_int
                | (ug & user_grp)
                | (wr ? wr_ok : rd_ok);

endmodule : ppl_perm_matrix

// ---- verification/ppl_lock_properties.sv ----
`timescale 1ns/1ps
module ppl_lock_chk (
   input wire logic              clk_sys,            // Clock
   input wire logic              rst_n,              // Reset
   input wire logic              req_valid,          // Request
   input wire ppl_pkg::ppl_src_e req_src,            // Source
   input wire logic              req_write,          // Direction
   input wire ppl_pkg::ppl_tgt_e req_tgt,            // Target
   input wire logic              rsp_valid,          // Answer
   input wire logic              rsp_ok,             // Done
   input wire logic              rsp_lock_ind,       // Lock refusal
   input wire logic [15:0]       rsp_rdata,          // Read value
   input wire logic [15:0]       lock_level_setting, // Level
   input wire logic              locked,             // Armed
   input wire logic              lockout,            // Five failures
   input wire logic              option_fault_trip,  // Trip
   input wire logic              all_clear_req,      // Clear
   input wire logic              all_clear_ack,      // Cleared
   input wire logic              all_clear_refused,  // Refused
   input wire logic              param_clear         // Clear others
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   rsp_follow_a:
      assert property (req_valid |=> rsp_valid) else $error("no answer");
   rsp_quiet_a:
      assert property (!req_valid |=> !rsp_valid && !rsp_ok && !rsp_lock_ind)
         else $error("answer without request");
   internal_ok_a:
      assert property (req_valid && req_src == ppl_pkg::PPL_SRC_INTERNAL |=> rsp_ok && !rsp_lock_ind)
         else $error("internal update refused");
   level_hold_a:
      assert property (locked && !all_clear_req |=> $stable(lock_level_setting))
         else $error("level changed while locked");
   clear_answer_a:
      assert property (all_clear_req |=> all_clear_ack != all_clear_refused)
         else $error("clear not answered once");
   clear_dflt_a:
      assert property (all_clear_ack |-> lock_level_setting == 16'h270f && !locked && !lockout
                       && param_clear) else $error("clear left state");
   lockout_lvl_a:
      assert property (lockout |-> lock_level_setting inside {[16'h0064:16'h006a], 16'h00c7})
         else $error("lockout at non-counting level");
   fault_lvl_a:
      assert property (option_fault_trip |-> $past(lock_level_setting) inside {16'h0000, 16'h0064})
         else $error("trip at wrong level");
   pw_read_a:
      assert property (req_valid && !req_write && req_tgt == ppl_pkg::PPL_TGT_PASSWORD && locked
                       |=> rsp_ok && rsp_rdata <= 16'h0005) else $error("password leaked");
endmodule : ppl_lock_chk

bind ppl_lock ppl_lock_chk chk (.clk_sys, .rst_n, .req_valid, .req_src, .req_write, .req_tgt,
   .rsp_valid, .rsp_ok, .rsp_lock_ind, .rsp_rdata, .lock_level_setting, .locked, .lockout,
   .option_fault_trip, .all_clear_req, .all_clear_ack, .all_clear_refused, .param_clear);

// ---- verification/ppl_src_model.sv ----
`timescale 1ns/1ps
module ppl_src_model (
   input  wire logic        clk_sys,      // Clock
   input  wire logic        rsp_valid,    // Answer
   input  wire logic        rsp_ok,       // Done
   input  wire logic        rsp_err,      // Error
   input  wire logic        rsp_lock_ind, // Lock refusal
   input  wire logic [15:0] rsp_rdata,    // Read value
   output ppl_pkg::ppl_src_e req_src,     // Source
   output logic             req_valid,    // Strobe
   output logic             req_write,    // Direction
   output ppl_pkg::ppl_tgt_e req_tgt,     // Target
   output logic             req_user_grp, // In user group
   output logic [15:0]      req_wdata     // Write value
);
   logic        ok;
   logic        err;
   logic        ind;
   logic [15:0] rdata;
   initial begin
      req_valid = 1'b0;
      req_src = ppl_pkg::PPL_SRC_PANEL;
      req_write = 1'b0;
      req_tgt = ppl_pkg::PPL_TGT_OTHER;
      req_user_grp = 1'b0;
      req_wdata = 16'h0000;
   end
   // Missing answer leaves unknowns, so every compare fails
   task automatic acc(input ppl_pkg::ppl_src_e s, input logic w, input ppl_pkg::ppl_tgt_e t,
                      input logic g, input logic [15:0] d);
      @(posedge clk_sys);
      #1;
      req_valid = 1'b1;
      req_src = s;
      req_write = w;
      req_tgt = t;
      req_user_grp = g;
      req_wdata = d;
      @(posedge clk_sys);
      #1;
      ok = rsp_valid ? rsp_ok : 1'bx;
      err = rsp_valid ? rsp_err : 1'bx;
      ind = rsp_valid ? rsp_lock_ind : 1'bx;
      rdata = rsp_valid ? rsp_rdata : 16'hxxxx;
      req_valid = 1'b0;
      req_wdata = ~d;
   endtask : acc
endmodule : ppl_src_model

// ---- verification/test_ppl_lock.sv ----
`timescale 1ns/1ps
module test_ppl_lock;
   localparam ppl_pkg::ppl_src_e PNL = ppl_pkg::PPL_SRC_PANEL;
   localparam ppl_pkg::ppl_tgt_e OTH = ppl_pkg::PPL_TGT_OTHER;
   logic clk_sys, rst_n, req_valid, req_write, req_user_grp, read_sel_block, write_sel_block;
   logic option_installed, drive_running, all_clear_req, rsp_valid, rsp_ok, rsp_err;
   logic rsp_lock_ind, locked, lockout, option_fault_trip, all_clear_ack, all_clear_refused;
   logic param_clear;
   logic [15:0] req_wdata, group_read_selection, rsp_rdata, lock_level_setting;
   ppl_pkg::ppl_src_e req_src;
   ppl_pkg::ppl_tgt_e req_tgt;
   int bad_count;
   int comparisons;
   ppl_src_model host (.clk_sys, .rsp_valid, .rsp_ok, .rsp_err, .rsp_lock_ind, .rsp_rdata,
                       .req_valid, .req_src, .req_write, .req_tgt, .req_user_grp, .req_wdata);
   ppl_lock dut (.clk_sys, .rst_n, .req_valid, .req_src, .req_write, .req_tgt, .req_user_grp,
      .req_wdata, .group_read_selection, .read_sel_block, .write_sel_block, .option_installed,
      .drive_running, .all_clear_req, .rsp_valid, .rsp_ok, .rsp_err, .rsp_lock_ind, .rsp_rdata,
      .lock_level_setting, .locked, .lockout, .option_fault_trip, .all_clear_ack,
      .all_clear_refused, .param_clear);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic c, input string m);
      comparisons++;
      if (c !== 1'b1) begin
         bad_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic lv(input logic [15:0] v);
      host.acc(PNL, 1'b1, ppl_pkg::PPL_TGT_LEVEL, 1'b0, v);
   endtask : lv
   task automatic pw(input logic w, input logic [15:0] v);
      host.acc(PNL, w, ppl_pkg::PPL_TGT_PASSWORD, 1'b0, v);
   endtask : pw
   task automatic clr();
      repeat (3) @(posedge clk_sys);
      #1 all_clear_req = 1'b1;
      @(posedge clk_sys);
      #1 all_clear_req = 1'b0;
   endtask : clr
   task automatic t_reset();
      chk(lock_level_setting === 16'h270f, "level reset");
      pw(1'b0, 16'h0000);
      chk(host.rdata === 16'h270f, "password reset");
      pw(1'b1, 16'h04d2);
      chk(host.err === 1'b1 && locked === 1'b0, "no level");
      lv(16'h0007);
      chk(host.err === 1'b1 && lock_level_setting === 16'h270f, "bad level");
   endtask : t_reset
   task automatic t_matrix();
      logic [15:0] lvl [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
                               16'h0006, 16'h0063};
      logic [5:0]  msk [8] = '{6'h00, 6'h15, 6'h3d, 6'h17, 6'h10, 6'h3c, 6'h13, 6'h3f};
      for (int i = 0; i < 8; i++) begin
         lv(lvl[i]);
         pw(1'b1, 16'h04d2);
         chk(locked === 1'b1, "arm");
         pw(1'b0, 16'h0000);
         chk(host.rdata === 16'h0000, "password hidden");
         for (int k = 0; k < 6; k++) begin
            host.acc(ppl_pkg::ppl_src_e'(k / 2), k[0], OTH, 1'b1, 16'h0001);
            chk(host.ok === msk[i][k] && host.ind === !msk[i][k], "matrix");
         end
         host.acc(PNL, 1'b0, OTH, 1'b0, 16'h0001);
         chk(host.ok === (i < 7 ? msk[i][0] : 1'b0), "outside group");
         pw(1'b1, 16'h04d2);
         chk(locked === 1'b0, "unlock");
      end
   endtask : t_matrix
   task automatic t_count();
      lv(16'h0068);
      pw(1'b1, 16'h0000);
      chk(host.ok === 1'b1 && locked === 1'b0, "noop write");
      pw(1'b1, 16'h04d2);
      for (int i = 1; i < 6; i++) begin
         pw(1'b1, 16'h0457);
         chk(host.err === 1'b1 && locked === 1'b1, "wrong password");
         pw(1'b0, 16'h0000);
         chk(host.rdata === 16'(i), "fail count");
      end
      pw(1'b1, 16'h04d2);
      chk(host.err === 1'b1 && host.ind === 1'b1 && lockout === 1'b1, "lockout");
      host.acc(ppl_pkg::PPL_SRC_INTERNAL, 1'b1, OTH, 1'b0, 16'h0001);
      chk(host.ok === 1'b1, "internal");
      drive_running = 1'b1;
      clr();
      chk(all_clear_refused === 1'b1 && locked === 1'b1, "clear running");
      chk(all_clear_ack === 1'b0 && param_clear === 1'b0, "clear held off");
      drive_running = 1'b0;
      clr();
      chk(param_clear === 1'b1 && lockout === 1'b0, "clear");
      chk(all_clear_ack === 1'b1 && all_clear_refused === 1'b0, "clear ack");
      chk(locked === 1'b0 && lock_level_setting === 16'h270f, "defaults");
   endtask : t_count
   task automatic t_select();
      lv(16'h0003);
      group_read_selection = 16'h0001;
      lv(16'h0005);
      chk(host.ok === 1'b0 && lock_level_setting === 16'h0003, "level held");
      host.acc(PNL, 1'b0, ppl_pkg::PPL_TGT_LEVEL, 1'b0, 16'h0000);
      chk(host.ok === 1'b1 && host.rdata === 16'h0003, "level read");
      pw(1'b1, 16'h04d2);
      chk(host.err === 1'b1 && locked === 1'b0, "password refused");
      group_read_selection = 16'h0000;
      pw(1'b1, 16'h04d2);
      group_read_selection = 16'h0001;
      pw(1'b1, 16'h04d2);
      chk(host.ok === 1'b1 && locked === 1'b0, "unlock");
      group_read_selection = 16'h0000;
      read_sel_block = 1'b1;
      write_sel_block = 1'b1;
      host.acc(PNL, 1'b0, OTH, 1'b0, 16'h0000);
      chk(host.ok === 1'b0 && host.ind === 1'b0, "read blocked");
      host.acc(PNL, 1'b1, OTH, 1'b0, 16'h0001);
      chk(host.ok === 1'b0 && host.ind === 1'b0, "write blocked");
      lv(16'h0002);
      chk(host.ok === 1'b1, "level writable");
      read_sel_block = 1'b0;
      write_sel_block = 1'b0;
   endtask : t_select
   task automatic t_fault();
      option_installed = 1'b1;
      lv(16'h0064);
      // Pin passes a two-stage synchroniser first
      repeat (4) @(posedge clk_sys);
      #1 chk(option_fault_trip === 1'b1, "trip");
      lv(16'h270f);
      // Trip follows the stored level one cycle later
      @(posedge clk_sys);
      #1 chk(option_fault_trip === 1'b0, "no trip");
      option_installed = 1'b0;
   endtask : t_fault
   task automatic close_out();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   initial begin
      rst_n = 1'b0;
      group_read_selection = 16'h0000;
      {read_sel_block, write_sel_block, option_installed, drive_running} = 4'h0;
      all_clear_req = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      t_reset();
      t_matrix();
      t_count();
      t_select();
      t_fault();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      close_out();
   end
endmodule : test_ppl_lock
